// >>> ahp_pkg.sv
// Purpose: shared constants for the converter host port control block
// Assumes: 10-bit control word and result registers
// Notes: counts are in conversion clock rising edges unless named cycles

package ahp_pkg;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 10;            // control and result width
  localparam int CHAN_A_LSB = 0;         // first channel address field
  localparam int CHAN_B_LSB = 3;         // second channel address field
  localparam int CHAN_W = 3;             // channel address width
  localparam int DUAL_SAMPLE_POS = 6;    // two-channel sampling bit
  localparam int HALF_SCALE_POS = 7;     // half-scale test bit
  localparam int POWERDOWN_POS = 8;      // powerdown bit
  localparam int FLAG_MODE_POS = 9;      // flag behaviour bit

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] CTRL_RESET = 10'h000;   // all zero at power-on
  localparam logic [9:0] RESULT_RESET = 10'h000; // results before any run

  // ----------------------------------------------------------------
  // timing in conversion clock edges
  // ----------------------------------------------------------------
  localparam logic [3:0] ACQ_EDGES = 4'h5;   // acquisition, 5 edges
  localparam logic [3:0] CONV_EDGES = 4'he;  // one conversion, 14 edges
  localparam int SYNC_STAGES = 2;            // pin synchroniser depth

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,   // no conversion running
    ST_ACQ = 3'b001,    // tracking the inputs after a write
    ST_CONV1 = 3'b010,  // first conversion
    ST_CONV2 = 3'b011,  // second conversion of a dual sample
    ST_PDOWN = 3'b100   // linear circuitry off
  } ahp_state_t;

endpackage

// >>> ahp_sync.sv
// Purpose: two-stage pin synchroniser with edge pulses
// Assumes: inputs are asynchronous to i_clock
// Notes: edges come from the second stage only

`timescale 1ns/100ps
`default_nettype none

module ahp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_init,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg;  // first stage, read by stage two only
  logic [WIDTH-1:0] sync_reg;  // safe level
  logic [WIDTH-1:0] last_reg;  // previous safe level for edges
  logic [WIDTH-1:0] init_q;    // edge mask, high blocks both edge pulses

  assign init_q = i_init;

  // all stages reset to zero; idle level applied once released
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // init mask suppresses false edges right after reset release
  assign o_level = sync_reg;
  assign o_rise = sync_reg & ~last_reg & ~init_q;
  assign o_fall = ~sync_reg & last_reg & ~init_q;

endmodule

`default_nettype wire

// >>> ahp_ctrl.sv
// Purpose: host port, sequencer, flag and powerdown control of a
//   multichannel successive-approximation converter
// Assumes: strobes, data and conversion clock are asynchronous pins
// Notes:

`timescale 1ns/100ps
`default_nettype none

module ahp_ctrl (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_port_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_read_strobe_n,
  input wire logic i_conv_clock,
  input wire logic [9:0] i_data_port,
  input wire logic [9:0] i_sar_data,
  output logic [9:0] o_data_port,
  output logic o_data_port_oe,
  output logic o_conv_flag_n,
  output logic o_powerdown,
  output logic o_acquire,
  output logic o_converting,
  output logic o_second_conv,
  output logic [2:0] o_chan_first,
  output logic [2:0] o_chan_second,
  output logic o_half_scale
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] strobe_lvl;   // {read, write, select}, all active low
  logic [2:0] strobe_rise;  // rising edges of the strobes
  logic [2:0] strobe_fall;  // falling edges of the strobes
  logic cclk_rise;          // conversion clock rising edge
  logic [9:0] data_lvl;     // synchronised data port

  // strobes idle high; edges are masked while the levels settle
  logic [2:0] strobe_mask_reg;
  logic [2:0] strobe_mask_next;

  ahp_sync #(.WIDTH(3)) u_strobe_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async({i_read_strobe_n, i_write_strobe_n, i_port_select_n}),
    // every strobe masked together until the stages hold the idle level
    .i_init({3{|strobe_mask_reg}}),
    .o_level(strobe_lvl),
    .o_rise(strobe_rise),
    .o_fall(strobe_fall)
  );

  ahp_sync #(.WIDTH(1)) u_cclk_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async(i_conv_clock),
    // a pin already high at release must not count as a clock edge
    .i_init(|strobe_mask_reg),
    .o_level(),
    .o_rise(cclk_rise),
    .o_fall()
  );

  ahp_sync #(.WIDTH(ahp_pkg::WORD_W)) u_data_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async(i_data_port),
    .i_init(10'h000),
    .o_level(data_lvl),
    .o_rise(),
    .o_fall()
  );

  // mask edges for the first cycles after release, level still zero
  always_comb begin
    strobe_mask_next = {strobe_mask_reg[1:0], 1'b0};
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      strobe_mask_reg <= 3'h7;
    end else begin
      strobe_mask_reg <= strobe_mask_next;
    end
  end

  // ----------------------------------------------------------------
  // qualified host accesses
  // ----------------------------------------------------------------
  logic cs_n;          // select level
  logic wr_n;          // write strobe level
  logic rd_n;          // read strobe level
  logic wr_start;      // leading edge of a write
  logic wr_end;        // trailing edge of a write, word taken here
  logic rd_start;      // leading edge of a read
  logic rd_end;        // trailing edge of a read

  assign cs_n = strobe_lvl[0];
  assign wr_n = strobe_lvl[1];
  assign rd_n = strobe_lvl[2];
  assign wr_start = strobe_fall[1] & ~cs_n & rd_n;
  assign wr_end = strobe_rise[1] & ~cs_n & rd_n;
  assign rd_start = strobe_fall[2] & ~cs_n & wr_n;
  assign rd_end = strobe_rise[2] & ~cs_n & wr_n;

  // busy decode, used by the sequencer, flag and read path
  function automatic logic is_busy(input ahp_pkg::ahp_state_t st);
    is_busy = (st == ahp_pkg::ST_ACQ) || (st == ahp_pkg::ST_CONV1) ||
              (st == ahp_pkg::ST_CONV2);
  endfunction

  // ----------------------------------------------------------------
  // control word
  // ----------------------------------------------------------------
  logic [9:0] ctrl_reg;   // write only, never put on the data port
  logic [9:0] ctrl_next;
  logic dual;             // two-channel sampling selected
  logic flag_mode;        // flag low after completion when set

  // whole word replaced only by a write; powerdown leaves it alone
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_end) begin
      ctrl_next = data_lvl;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= ahp_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign dual = ctrl_reg[ahp_pkg::DUAL_SAMPLE_POS];
  assign flag_mode = ctrl_reg[ahp_pkg::FLAG_MODE_POS];

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  ahp_pkg::ahp_state_t state_reg;
  ahp_pkg::ahp_state_t state_next;
  logic [3:0] edge_reg;   // conversion clock edges in this phase
  logic [3:0] edge_next;
  logic end_first;        // first conversion finished this cycle
  logic end_second;       // second conversion finished this cycle
  logic seq_done;         // whole sequence finished this cycle

  // write end has top priority: it starts a sequence or powers down
  always_comb begin
    state_next = state_reg;
    edge_next = edge_reg;
    end_first = 1'b0;
    end_second = 1'b0;
    if (wr_end) begin
      edge_next = 4'h0;
      if (data_lvl[ahp_pkg::POWERDOWN_POS]) begin
        state_next = ahp_pkg::ST_PDOWN;
      end else begin
        state_next = ahp_pkg::ST_ACQ;
      end
    end else if ((wr_start || rd_start) && is_busy(state_reg)) begin
      state_next = ahp_pkg::ST_IDLE;
      edge_next = 4'h0;
    end else begin
      unique case (state_reg)
        ahp_pkg::ST_IDLE: begin
          state_next = ahp_pkg::ST_IDLE;  // waits for a write
        end
        ahp_pkg::ST_ACQ: begin
          if (cclk_rise) begin
            edge_next = edge_reg + 4'h1;
            if (edge_reg == ahp_pkg::ACQ_EDGES - 4'h1) begin
              state_next = ahp_pkg::ST_CONV1;
              edge_next = 4'h0;
            end
          end
        end
        ahp_pkg::ST_CONV1, ahp_pkg::ST_CONV2: begin
          if (cclk_rise) begin
            edge_next = edge_reg + 4'h1;
            if (edge_reg == ahp_pkg::CONV_EDGES - 4'h1) begin
              edge_next = 4'h0;
              if (state_reg == ahp_pkg::ST_CONV2) begin
                end_second = 1'b1;
                state_next = ahp_pkg::ST_IDLE;
              end else begin
                end_first = 1'b1;
                state_next = dual ? ahp_pkg::ST_CONV2 :
                             ahp_pkg::ST_IDLE;
              end
            end
          end
        end
        ahp_pkg::ST_PDOWN: begin
          state_next = ahp_pkg::ST_PDOWN;  // only a write brings it back
        end
        default: begin
          state_next = ahp_pkg::ST_IDLE;  // illegal code recovers
          edge_next = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ahp_pkg::ST_IDLE;
      edge_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      edge_reg <= edge_next;
    end
  end

  assign seq_done = end_second | (end_first & ~dual);

  // ----------------------------------------------------------------
  // busy / done flag
  // ----------------------------------------------------------------
  logic flag_n_reg;   // pin level, low means busy or done by mode
  logic flag_n_next;

  // a write leading edge always parks the flag high first
  always_comb begin
    flag_n_next = flag_n_reg;
    if (state_reg == ahp_pkg::ST_PDOWN && !wr_end) begin
      flag_n_next = 1'b1;
    end else if (wr_end) begin
      if (data_lvl[ahp_pkg::POWERDOWN_POS]) begin
        flag_n_next = 1'b1;
      end else begin
        flag_n_next = data_lvl[ahp_pkg::FLAG_MODE_POS];
      end
    end else if (wr_start) begin
      flag_n_next = 1'b1;
    end else if (rd_start && is_busy(state_reg)) begin
      flag_n_next = 1'b1;  // aborted, neither busy nor done
    end else if (seq_done) begin
      flag_n_next = ~flag_mode;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_n_reg <= 1'b1;
    end else begin
      flag_n_reg <= flag_n_next;
    end
  end

  // ----------------------------------------------------------------
  // result registers and read path
  // ----------------------------------------------------------------
  logic [9:0] first_reg;    // result_reg_first
  logic [9:0] first_next;
  logic [9:0] second_reg;   // result_reg_second
  logic [9:0] second_next;
  logic sel_reg;            // next read returns second when set
  logic sel_next;
  logic [9:0] dout_reg;     // data port output word
  logic [9:0] dout_next;

  // results written only at conversion end, never in powerdown
  always_comb begin
    first_next = first_reg;
    second_next = second_reg;
    sel_next = sel_reg;
    dout_next = dout_reg;
    if (end_first) begin
      first_next = i_sar_data;
    end
    if (end_second) begin
      second_next = i_sar_data;
    end
    if (seq_done || wr_end) begin
      sel_next = 1'b0;
    end else if (rd_end && dual) begin
      sel_next = ~sel_reg;
    end
    if (rd_start) begin
      if (is_busy(state_reg)) begin
        dout_next = i_sar_data;  // partial word, not valid
      end else if (sel_reg && dual) begin
        dout_next = second_reg;
      end else begin
        dout_next = first_reg;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      first_reg <= ahp_pkg::RESULT_RESET;
      second_reg <= ahp_pkg::RESULT_RESET;
      sel_reg <= 1'b0;
      dout_reg <= ahp_pkg::RESULT_RESET;
    end else begin
      first_reg <= first_next;
      second_reg <= second_next;
      sel_reg <= sel_next;
      dout_reg <= dout_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // released whenever select is high, whatever the strobes do
  assign o_data_port_oe = ~cs_n & ~rd_n & wr_n;
  assign o_data_port = dout_reg;
  assign o_conv_flag_n = flag_n_reg;
  assign o_powerdown = (state_reg == ahp_pkg::ST_PDOWN);
  assign o_acquire = (state_reg == ahp_pkg::ST_ACQ);
  assign o_converting = (state_reg == ahp_pkg::ST_CONV1) ||
                        (state_reg == ahp_pkg::ST_CONV2);
  assign o_second_conv = (state_reg == ahp_pkg::ST_CONV2);
  assign o_chan_first = ctrl_reg[ahp_pkg::CHAN_A_LSB +: ahp_pkg::CHAN_W];
  assign o_chan_second = ctrl_reg[ahp_pkg::CHAN_B_LSB +: ahp_pkg::CHAN_W];
  assign o_half_scale = ctrl_reg[ahp_pkg::HALF_SCALE_POS];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  a_pdown_flag_high: assert property (
    state_reg == ahp_pkg::ST_PDOWN |-> o_conv_flag_n)
    else $error("flag low during powerdown");

  a_select_hiz: assert property (cs_n |-> !o_data_port_oe)
    else $error("data port driven with select high");

  a_write_abort: assert property (
    wr_start && !wr_end && is_busy(state_reg) |=>
      o_conv_flag_n && state_reg == ahp_pkg::ST_IDLE)
    else $error("write did not abort conversion");

  a_pdown_enter: assert property (
    wr_end && data_lvl[ahp_pkg::POWERDOWN_POS] |=>
      o_powerdown && $stable(first_reg) && $stable(second_reg))
    else $error("powerdown write not taken");

  a_pdown_exit: assert property (
    wr_end && !data_lvl[ahp_pkg::POWERDOWN_POS] |=> o_acquire)
    else $error("no sequence after write");

  a_read_abort: assert property (
    rd_start && !wr_end && is_busy(state_reg) |=>
      state_reg == ahp_pkg::ST_IDLE)
    else $error("read did not halt conversion");

  a_single_read: assert property (
    rd_start && !is_busy(state_reg) && !dual |=>
      dout_reg == $past(first_reg))
    else $error("single mode read not first result");

  a_dual_toggle: assert property (
    rd_end && dual && !seq_done && !wr_end |=> sel_reg != $past(sel_reg))
    else $error("dual mode reads do not alternate");

  a_busy_mode: assert property (
    o_converting && !flag_mode |-> !o_conv_flag_n)
    else $error("flag not low during conversion");

  a_conv_count: assert property (
    o_converting |-> edge_reg < ahp_pkg::CONV_EDGES)
    else $error("conversion ran past its length");

  a_first_flag_kept: assert property (
    end_first && dual && !wr_start && !rd_start |=>
      $stable(o_conv_flag_n) && o_second_conv)
    else $error("first of dual changed the flag");

  a_pdown_ctrl_kept: assert property (
    o_powerdown && !wr_end |=> $stable(ctrl_reg))
    else $error("control word changed in powerdown");

  c_dual_done: cover property (end_second);
  c_pdown_cycle: cover property (o_powerdown ##[1:1000] o_acquire);
  c_read_abort: cover property (rd_start && o_converting);
  c_write_abort: cover property (wr_start && o_acquire);

endmodule

`default_nettype wire

// >>> ahp_host_model.sv
// Purpose: host bus model for the converter parallel port
// Assumes: strobes move 1 ns after a system clock edge
// Notes: a released bus shows the inverse of its last word

`timescale 1ns/100ps
`default_nettype none

module ahp_host_model (
  input wire logic i_clock,
  input wire logic [9:0] i_dev_data,
  input wire logic i_dev_oe,
  output var logic o_port_select_n,
  output var logic o_write_strobe_n,
  output var logic o_read_strobe_n,
  output logic [9:0] o_bus
);
  // ------------------------------------------------------------
  // bus state
  // ------------------------------------------------------------
  logic [9:0] drv_word = 10'h000; // host drive value
  logic drv_en = 1'b0; // host drives the wire
  logic [9:0] last_word = 10'h000; // last driven level

  // strobes parked high from time zero, before reset release
  initial begin
    o_port_select_n = 1'b1;
    o_write_strobe_n = 1'b1;
    o_read_strobe_n = 1'b1;
  end

  // wire level: device, else host, else a floating pattern
  assign o_bus = i_dev_oe ? i_dev_data : (drv_en ? drv_word : ~last_word);

  // remember the driven level so release shows something else
  always @(posedge i_clock) begin
    if (i_dev_oe || drv_en) begin
      last_word <= o_bus;
    end
  end

  // write: data settles long before the strobe rises
  task automatic wr(input logic [9:0] word);
    @(posedge i_clock);
    #1;
    o_port_select_n = 1'b0;
    drv_word = word;
    drv_en = 1'b1;
    repeat (4) @(posedge i_clock);
    #1;
    o_write_strobe_n = 1'b0;
    repeat (5) @(posedge i_clock);
    #1;
    o_write_strobe_n = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    o_port_select_n = 1'b1;
    drv_en = 1'b0;
    repeat (4) @(posedge i_clock);
  endtask

  // read: word taken at the edge before the strobe lifts
  task automatic rd(output logic [9:0] word);
    @(posedge i_clock);
    #1;
    o_port_select_n = 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    o_read_strobe_n = 1'b0;
    repeat (6) @(posedge i_clock);
    word = o_bus;
    #1;
    o_read_strobe_n = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    o_port_select_n = 1'b1;
    repeat (4) @(posedge i_clock);
  endtask
endmodule

`default_nettype wire

// >>> test_ahp_ctrl.sv
// Purpose: self-checking bench for the host port control block
// Assumes: conversion clock 25 MHz, unrelated in phase
// Notes: front end word follows which conversion is running

`timescale 1ns/100ps
`default_nettype none

module test_ahp_ctrl;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clock = 1'b0; // system clock
  logic nrst = 1'b0; // reset, active low
  logic conv_clock = 1'b0; // conversion clock
  logic [9:0] val_a = 10'h000; // first conversion word
  logic [9:0] val_b = 10'h000; // second conversion word
  logic [9:0] rdv; // read result
  wire [9:0] bus, dev_data, sar;
  wire cs_n, wr_n, rd_n, oe, flag_n, pdown, acq, conv, second, half;
  wire [2:0] chan_a, chan_b;
  int n_fail = 0, checks_done = 0, cycles = 0;
  int conv_cycles = 0, acq_cycles = 0;

  // front end: word picked by the running conversion
  assign sar = second ? val_b : val_a;

  always #4 clock = ~clock;
  initial begin
    #3;
    // clock parked at its level while powered down
    forever #20 conv_clock = pdown ? conv_clock : ~conv_clock;
  end

  ahp_host_model ahp_host_model_inst (.i_clock(clock),
    .i_dev_data(dev_data), .i_dev_oe(oe), .o_port_select_n(cs_n),
    .o_write_strobe_n(wr_n), .o_read_strobe_n(rd_n), .o_bus(bus));

  ahp_ctrl ahp_ctrl_inst (.i_clock(clock), .i_nrst(nrst),
    .i_port_select_n(cs_n), .i_write_strobe_n(wr_n),
    .i_read_strobe_n(rd_n), .i_conv_clock(conv_clock),
    .i_data_port(bus), .i_sar_data(sar), .o_data_port(dev_data),
    .o_data_port_oe(oe), .o_conv_flag_n(flag_n), .o_powerdown(pdown),
    .o_acquire(acq), .o_converting(conv), .o_second_conv(second),
    .o_chan_first(chan_a), .o_chan_second(chan_b), .o_half_scale(half));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // phase lengths and a hang ceiling
  always @(posedge clock) begin
    cycles++;
    if (conv) conv_cycles++;
    if (acq) acq_cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // control word: mode, powerdown, half, dual, chan b, chan a
  function automatic logic [9:0] cw(input logic fm, input logic pd,
    input logic hs, input logic du, input logic [2:0] b,
    input logic [2:0] a);
    return {fm, pd, hs, du, b, a};
  endfunction

  // bounded wait: 0 flag, 1 converting, 2 second conversion
  task automatic wait_bit(input int which, input logic lvl);
    int i;
    for (i = 0; i < 3000; i++) begin
      if ((which == 0 ? flag_n : which == 1 ? conv : second) === lvl)
        break;
      @(posedge clock);
    end
    if (i == 3000) n_fail++;
  endtask

  task automatic do_rd(input logic [9:0] exp);
    ahp_host_model_inst.rd(rdv);
    check(rdv, exp);
  endtask

  // write that checks the flag a few cycles after the strobe falls
  task automatic wr_flag(input logic [9:0] w);
    fork
      ahp_host_model_inst.wr(w);
      begin
        wait (wr_n === 1'b0);
        repeat (5) @(posedge clock);
        check({9'h000, flag_n}, 10'h001);
      end
    join
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (6) @(posedge clock);
    check({9'h000, flag_n}, 10'h001);
    check({3'h0, half, chan_b, chan_a}, 10'h000);
    // read strobe with select high leaves the port released
    #1 ahp_host_model_inst.o_read_strobe_n = 1'b0;
    repeat (6) @(posedge clock);
    check({9'h000, oe}, 10'h000);
    #1 ahp_host_model_inst.o_read_strobe_n = 1'b1;
    // single conversion, busy flag mode
    val_a = 10'h2a5;
    conv_cycles = 0;
    acq_cycles = 0;
    ahp_host_model_inst.wr(cw(0, 0, 1, 0, 3'h2, 3'h5));
    check({3'h0, half, chan_b, chan_a}, 10'h055);
    check({9'h000, flag_n}, 10'h000);
    wait_bit(0, 1'b1);
    check({9'h000, conv_cycles >= 65 && conv_cycles <= 75}, 10'h001);
    check({9'h000, acq_cycles >= 20 && acq_cycles <= 30}, 10'h001);
    do_rd(10'h2a5);
    do_rd(10'h2a5);
    // dual conversion, done flag mode
    val_a = 10'h155;
    val_b = 10'h0ca;
    ahp_host_model_inst.wr(cw(1, 0, 0, 1, 3'h7, 3'h1));
    check({9'h000, flag_n}, 10'h001);
    wait_bit(2, 1'b1);
    check({9'h000, flag_n}, 10'h001);
    wait_bit(0, 1'b0);
    do_rd(10'h155);
    do_rd(10'h0ca);
    do_rd(10'h155);
    val_a = 10'h311;
    ahp_host_model_inst.wr(cw(1, 0, 0, 1, 3'h7, 3'h1));
    wait_bit(0, 1'b0);
    do_rd(10'h311);
    // read during a conversion returns the live word
    val_a = 10'h3c3;
    ahp_host_model_inst.wr(cw(0, 0, 0, 0, 3'h0, 3'h0));
    wait_bit(1, 1'b1);
    do_rd(10'h3c3);
    check({9'h000, conv}, 10'h000);
    // write during a conversion restarts the sequence
    ahp_host_model_inst.wr(cw(0, 0, 0, 0, 3'h0, 3'h0));
    wait_bit(1, 1'b1);
    #1 val_a = 10'h066;
    wr_flag(cw(0, 0, 0, 0, 3'h0, 3'h6));
    wait_bit(0, 1'b1);
    do_rd(10'h066);
    // powerdown while idle keeps results readable
    val_a = 10'h1e1;
    val_b = 10'h21d;
    ahp_host_model_inst.wr(cw(0, 0, 0, 1, 3'h3, 3'h4));
    wait_bit(0, 1'b1);
    ahp_host_model_inst.wr(cw(0, 1, 0, 1, 3'h3, 3'h4));
    check({8'h00, pdown, flag_n}, 10'h003);
    check({4'h0, chan_b, chan_a}, 10'h01c);
    do_rd(10'h1e1);
    do_rd(10'h21d);
    val_a = 10'h0f0;
    val_b = 10'h30f;
    ahp_host_model_inst.wr(cw(0, 0, 0, 1, 3'h3, 3'h4));
    check({9'h000, pdown}, 10'h000);
    wait_bit(0, 1'b1);
    do_rd(10'h0f0);
    do_rd(10'h30f);
    // powerdown during a conversion stores nothing
    ahp_host_model_inst.wr(cw(0, 0, 0, 0, 3'h3, 3'h4));
    wait_bit(1, 1'b1);
    #1 val_a = 10'h2ff;
    wr_flag(cw(0, 1, 0, 0, 3'h3, 3'h4));
    check({8'h00, conv, pdown}, 10'h001);
    do_rd(10'h0f0);
    ahp_host_model_inst.wr(cw(0, 0, 0, 0, 3'h3, 3'h4));
    wait_bit(0, 1'b1);
    do_rd(10'h2ff);
    final_report();
  end
endmodule

`default_nettype wire
